/* File: hdl/lhnsp_consts.vh */
// Constants for the host nibble/serial port of the display controller.
// Assumes one 10 MHz system clock that oversamples every host pin.
//
// Summary of operation
// - Parallel mode moves nibbles over four three-state lines, both ways.
// - Parallel mode samples the four data lines on each strobe rise.
// - First rise fills upper nibble, second rise fills lower nibble.
// - Parallel reads change the data lines on strobe falling edges.
// - Parallel read: upper nibble after first fall, lower after second.
// - Serial mode: line 0 is serial input, line 3 is serial output.
// - Serial mode: line 1 selects mode, line 2 enables address match.
// - Serial bits shift in on shift clock rises, first bit is MSB.
// - Serial output goes MSB first, one bit per shift clock falling edge.
// - Mode level latched at reset release; high parallel, low serial.
// - Byte accepted on second strobe rise or eighth shift clock rise.
// - Busy goes low at byte completion, high when processing ends with the buffer not full.
// - Chip select high floats data lines and busy regardless of state.

`ifndef LHNSP_CONSTS_VH
`define LHNSP_CONSTS_VH

// Data line roles
`define LHNSP_LINE_SER_IN      0
`define LHNSP_LINE_MODE_SEL    1
`define LHNSP_LINE_ADDR_EN     2
`define LHNSP_LINE_SER_OUT     3

// Transfer lengths, as last count value of a byte
`define LHNSP_PAR_LAST         3'h1
`define LHNSP_SER_LAST         3'h7

// Reset values and pin enable patterns
`define LHNSP_CNT_RST          3'h0
`define LHNSP_SHIFT_RST        8'h00
`define LHNSP_NIBBLE_RST       4'h0
`define LHNSP_OE_OFF           4'h0
`define LHNSP_OE_PAR           4'hF
`define LHNSP_OE_SER           4'h8

`endif

/* File: hdl/lhnsp_port.v */
// Host transfer port: nibble parallel or bit serial byte exchange.
// Assumes all host pins are asynchronous to clock and much slower than it;
// the core on the user side runs on the same clock.

`include "lhnsp_consts.vh"

module lhnsp_port
(
   // System
   input  wire       clock,
   input  wire       rst,
   // Host pins, data lines split into in, out and enable
   input  wire [3:0] nibble_data_lines_in,
   output reg  [3:0] nibble_data_lines_out,
   output reg  [3:0] nibble_data_lines_oe,
   input  wire       host_strobe_n,
   input  wire       chip_select_n,
   input  wire       cmd_data_sel,
   output reg        busy_n_out,
   output reg        busy_n_oe,
   // Latched interface configuration
   output reg        par_mode,
   output reg        addr_match_enable,
   // Received bytes toward the core
   output reg        rx_valid,
   output reg  [7:0] rx_data,
   output reg        rx_is_cmd,
   input  wire       rx_ready,
   // Read data and processing status from the core
   input  wire       tx_load,
   input  wire [7:0] tx_data,
   input  wire       proc_done
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   reg [3:0] nib_s1_reg;
   reg [3:0] nib_s2_reg;
   reg       stb_s1_reg;
   reg       stb_s2_reg;
   reg       stb_s3_reg;
   reg       cs_s1_reg;
   reg       cs_s2_reg;
   reg       cd_s1_reg;
   reg       cd_s2_reg;

   // Not reset: pin synchronisers only, and mode latch must see the real pin
   always @(posedge clock)
   begin
      nib_s1_reg <= nibble_data_lines_in;
      nib_s2_reg <= nib_s1_reg;
      stb_s1_reg <= host_strobe_n;
      stb_s2_reg <= stb_s1_reg;
      stb_s3_reg <= stb_s2_reg;
      cs_s1_reg  <= chip_select_n;
      cs_s2_reg  <= cs_s1_reg;
      cd_s1_reg  <= cmd_data_sel;
      cd_s2_reg  <= cd_s1_reg;
   end

   wire stb_rise;
   wire stb_fall;
   wire selected;

   assign stb_rise = stb_s2_reg & ~stb_s3_reg;
   assign stb_fall = ~stb_s2_reg & stb_s3_reg;
   assign selected = ~cs_s2_reg;

   ////////////////////////////////////////////////////////////////////////
   // Mode latch at reset release

   reg rst_d_reg;

   always @(posedge clock)
   begin
      if (rst)
      begin
         rst_d_reg         <= 1'b1;
         par_mode          <= 1'b0;
         addr_match_enable <= 1'b0;
      end
      else
      begin
         rst_d_reg <= 1'b0;
         if (rst_d_reg)
         begin
            par_mode          <= nib_s2_reg[`LHNSP_LINE_MODE_SEL];
            addr_match_enable <= nib_s2_reg[`LHNSP_LINE_ADDR_EN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift/holding register and position counter

   reg  [7:0] shift_reg;
   reg  [2:0] cnt_reg;
   reg        read_mode_reg;
   reg        busy_reg;
   reg        active_reg;
   wire       buf_full;
   wire       take_edge;
   wire       last_pos;
   wire       byte_done;

   // Edges are ignored while busy: host must wait anyway
   assign take_edge = selected & ~busy_reg & active_reg;
   assign last_pos  = par_mode ? (cnt_reg == `LHNSP_PAR_LAST)
                               : (cnt_reg == `LHNSP_SER_LAST);
   assign byte_done = take_edge & stb_rise & last_pos;

   always @(posedge clock)
   begin
      if (rst)
      begin
         shift_reg             <= `LHNSP_SHIFT_RST;
         cnt_reg               <= `LHNSP_CNT_RST;
         read_mode_reg         <= 1'b0;
         nibble_data_lines_out <= `LHNSP_NIBBLE_RST;
         active_reg            <= 1'b0;
      end
      else
      begin
         // First cycle after release still holds the mode latch
         active_reg <= ~rst_d_reg;
         if (tx_load && !busy_reg)
         begin
            shift_reg     <= tx_data;
            read_mode_reg <= 1'b1;
            cnt_reg       <= `LHNSP_CNT_RST;
         end
         else if (!selected)
            cnt_reg <= `LHNSP_CNT_RST;
         else if (take_edge && stb_rise)
         begin
            if (!read_mode_reg)
            begin
               if (par_mode)
               begin
                  if (cnt_reg == `LHNSP_CNT_RST)
                     shift_reg[7:4] <= nib_s2_reg;
                  else
                     shift_reg[3:0] <= nib_s2_reg;
               end
               else
                  shift_reg <= {shift_reg[6:0],
                                nib_s2_reg[`LHNSP_LINE_SER_IN]};
            end
            if (last_pos)
            begin
               cnt_reg       <= `LHNSP_CNT_RST;
               read_mode_reg <= 1'b0;
            end
            else
               cnt_reg <= cnt_reg + 3'h1;
         end
         else if (take_edge && stb_fall && read_mode_reg)
         begin
            if (par_mode)
               nibble_data_lines_out <= (cnt_reg == `LHNSP_CNT_RST) ?
                  shift_reg[7:4] : shift_reg[3:0];
            else
            begin
               nibble_data_lines_out <= {shift_reg[7], 3'h0};
               shift_reg <= {shift_reg[6:0], 1'b0};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Busy and pin enables

   always @(posedge clock)
   begin
      if (rst)
      begin
         busy_reg             <= 1'b0;
         busy_n_out           <= 1'b1;
         busy_n_oe            <= 1'b0;
         nibble_data_lines_oe <= `LHNSP_OE_OFF;
      end
      else
      begin
         // Held busy while buffer full so no finished byte is dropped
         if (byte_done)
            busy_reg <= 1'b1;
         else if (proc_done && !buf_full)
            busy_reg <= 1'b0;
         busy_n_out <= ~(busy_reg | byte_done);
         busy_n_oe  <= selected;
         if (!selected || !read_mode_reg)
            nibble_data_lines_oe <= `LHNSP_OE_OFF;
         else if (par_mode)
            nibble_data_lines_oe <= `LHNSP_OE_PAR;
         else
            nibble_data_lines_oe <= `LHNSP_OE_SER;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-entry buffer toward the core; head entry is the output flop

   reg       valid1_reg;
   reg [7:0] data1_reg;
   reg       cmd1_reg;
   wire      push;
   wire      pop;
   wire [7:0] push_data;

   assign push      = byte_done & ~read_mode_reg;
   assign pop       = rx_valid & rx_ready;
   assign buf_full  = valid1_reg;
   assign push_data = par_mode ? {shift_reg[7:4], nib_s2_reg}
                               : {shift_reg[6:0],
                                  nib_s2_reg[`LHNSP_LINE_SER_IN]};

   always @(posedge clock)
   begin
      if (rst)
      begin
         rx_valid   <= 1'b0;
         rx_data    <= `LHNSP_SHIFT_RST;
         rx_is_cmd  <= 1'b0;
         valid1_reg <= 1'b0;
         data1_reg  <= `LHNSP_SHIFT_RST;
         cmd1_reg   <= 1'b0;
      end
      else if (pop)
      begin
         rx_valid <= valid1_reg | push;
         if (valid1_reg)
         begin
            rx_data   <= data1_reg;
            rx_is_cmd <= cmd1_reg;
         end
         else if (push)
         begin
            rx_data   <= push_data;
            rx_is_cmd <= cd_s2_reg;
         end
         valid1_reg <= valid1_reg & push;
         if (valid1_reg && push)
         begin
            data1_reg <= push_data;
            cmd1_reg  <= cd_s2_reg;
         end
      end
      else if (push)
      begin
         if (!rx_valid)
         begin
            rx_valid  <= 1'b1;
            rx_data   <= push_data;
            rx_is_cmd <= cd_s2_reg;
         end
         else
         begin
            valid1_reg <= 1'b1;
            data1_reg  <= push_data;
            cmd1_reg   <= cd_s2_reg;
         end
      end
   end

endmodule

/* File: testbench/lhnsp_port_checker.sv */
// Checker: pin, buffer and busy relations of the host port.
// Assumes one clock domain; bound to every lhnsp_port.
module lhnsp_port_checker
(
   // System
   input wire       clock,
   input wire       rst,
   // Pins
   input wire [3:0] nibble_data_lines_out,
   input wire [3:0] nibble_data_lines_oe,
   input wire       host_strobe_n,
   input wire       chip_select_n,
   input wire       busy_n_out,
   input wire       busy_n_oe,
   input wire       par_mode,
   input wire       addr_match_enable,
   // Core side
   input wire       rx_valid,
   input wire [7:0] rx_data,
   input wire       rx_is_cmd,
   input wire       rx_ready,
   input wire       tx_load,
   input wire       proc_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_held;
      rx_valid && !rx_ready;
   endsequence
   sequence s_done;
      $past(proc_done) || $past(proc_done, 2);
   endsequence
   ////////////////////////////////////////////////////////////////////
   cs_float_a: assert property (chip_select_n [*6] |->
      nibble_data_lines_oe == 4'h0 && !busy_n_oe) else $error("pins driven");
   busy_on_a: assert property (!chip_select_n [*6] |->
      busy_n_oe) else $error("busy pin floats");
   oe_mode_a: assert property (|nibble_data_lines_oe |->
      nibble_data_lines_oe == (par_mode ? 4'hF : 4'h8)) else $error("bad oe");
   mode_keep_a: assert property (!$past(rst,3) && !$past(rst,2) &&
      !$past(rst) |-> $stable(par_mode) && $stable(addr_match_enable))
      else $error("mode moved");
   push_busy_a: assert property ($rose(rx_valid) |-> !busy_n_out)
      else $error("byte without busy");
   busy_rel_a: assert property ($rose(busy_n_out) |-> s_done)
      else $error("busy freed early");
   rx_hold_a: assert property (s_held |=> rx_valid && $stable(rx_data)
      && $stable(rx_is_cmd)) else $error("head lost");
   // Drive starts two edges after a load, or three after reselect
   read_oe_a: assert property ($rose(|nibble_data_lines_oe) |->
      $past(tx_load, 2) || $past(chip_select_n, 4))
      else $error("drive without load");
   out_step_a: assert property (|nibble_data_lines_oe &&
      $past(|nibble_data_lines_oe) && $changed(nibble_data_lines_out)
      |-> !$past(host_strobe_n, 3)) else $error("out moved off fall");
endmodule
bind lhnsp_port lhnsp_port_checker u_lhnsp_port_checker (.*);

/* File: testbench/lhnsp_host.sv */
// Host model: strobe, select, command flag and data pins.
// Assumes calls from the bench; pins move 10 ns after clock edges.
module lhnsp_host
(
   // Clock
   input  wire       clock,
   // Data pins
   input  wire [3:0] dev_out,
   input  wire [3:0] dev_oe,
   output wire [3:0] lines,
   // Control pins
   output logic      strobe_n,
   output logic      cs_n,
   output logic      cd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] he = 4'h0;
   logic [3:0] hd = 4'h0;
   logic       pat = 1'b0;
   initial
   begin
      strobe_n = 1'b1;
      cs_n = 1'b0;
      cd = 1'b0;
   end
   // Undriven lines toggle so a stale level never passes as data
   always @(posedge clock) pat <= ~pat;
   assign lines = (dev_oe & dev_out) | (~dev_oe & he & hd)
                | (~dev_oe & ~he & {4{pat}});
   ////////////////////////////////////////////////////////////////////
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
      #10;
   endtask
   task automatic sel(input logic v);
      cs_n = v;
   endtask
   // Random shift clock while deselected; ends high
   task automatic jitter(input int c);
      for (int i = 0; i < c; i++)
      begin
         strobe_n = 1'($urandom_range(1));
         tick(1);
      end
      strobe_n = 1'b1;
   endtask
   task automatic cfg(input logic m, input logic a);
      he = 4'h6;
      hd = {1'b0, a, m, 1'b0};
   endtask
   task automatic xfer(input logic par, input logic wr, input logic c,
                       input logic [7:0] wb, output logic [7:0] rb);
      int n;
      n = par ? 2 : 8;
      rb = 8'h00;
      tick(1);
      cd = c;
      he = par ? {4{wr}} : 4'h7;
      for (int i = 0; i < n; i++)
      begin
         strobe_n = 1'b0;
         hd = par ? wb[7 - 4 * i -: 4] : {3'h0, wb[7 - i]};
         tick(4);
         if (par)
            rb[7 - 4 * i -: 4] = lines;
         else
            rb[7 - i] = lines[3];
         strobe_n = 1'b1;
         tick(4);
      end
   endtask
endmodule

/* File: testbench/lhnsp_port_bench.sv */
// Bench: writes, buffer fill, reads, busy and deselect in both modes.
// Assumes the host model and the bound checker.
module lhnsp_port_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       rx_ready = 1'b0;
   logic       tx_load = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic       proc_done = 1'b0;
   wire  [3:0] lines, d_out, d_oe;
   wire        stb_n, cs_n, cd, busy_n, busy_oe, par_o, cae_o, rxv, rxc;
   wire  [7:0] rxd;
   int         mismatches = 0;
   int         total_checks = 0;
   logic [8:0] q [$];
   logic [7:0] r, b;
   logic       md, c;
   lhnsp_port u_lhnsp_port
   (
      .clock(clock), .rst(rst), .nibble_data_lines_in(lines),
      .nibble_data_lines_out(d_out), .nibble_data_lines_oe(d_oe),
      .host_strobe_n(stb_n), .chip_select_n(cs_n), .cmd_data_sel(cd),
      .busy_n_out(busy_n), .busy_n_oe(busy_oe), .par_mode(par_o),
      .addr_match_enable(cae_o), .rx_valid(rxv), .rx_data(rxd),
      .rx_is_cmd(rxc), .rx_ready(rx_ready), .tx_load(tx_load),
      .tx_data(tx_data), .proc_done(proc_done)
   );
   lhnsp_host u_lhnsp_host
   (
      .clock(clock), .dev_out(d_out), .dev_oe(d_oe), .lines(lines),
      .strobe_n(stb_n), .cs_n(cs_n), .cd(cd)
   );
   initial
   begin
      forever #50 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string w, input logic [8:0] e, s);
      total_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_busy(input logic lvl);
      for (int n = 0; busy_n !== lvl; n++)
      begin
         u_lhnsp_host.tick(1);
         if (n > 300)
         begin
            check("busy wait", {8'h0, lvl}, {8'h0, ~lvl});
            complete_run();
         end
      end
   endtask
   task automatic pop;
      check("rx head", q.pop_front(), {rxc, rxd});
      // Random stall cycles before the take; head must hold
      for (int i = 0; i < 8; i++)
      begin
         rx_ready = (i == 7) ? 1'b1 : 1'($urandom_range(1));
         u_lhnsp_host.tick(1);
         if (rx_ready)
            break;
      end
      rx_ready = 1'b0;
      u_lhnsp_host.tick(1);
   endtask
   task automatic release_busy;
      for (int n = 0; busy_n !== 1'b1; n++)
      begin
         proc_done = 1'($urandom_range(1));
         u_lhnsp_host.tick(1);
         if (n > 300)
         begin
            check("busy release", 9'h1, {8'h0, busy_n});
            complete_run();
         end
      end
      proc_done = 1'b0;
   endtask
   task automatic do_reset(input logic m, a);
      u_lhnsp_host.cfg(m, a);
      rst = 1'b1;
      u_lhnsp_host.tick(4);
      rst = 1'b0;
      u_lhnsp_host.tick(8);
      check("mode", {7'h0, m, a}, {7'h0, par_o, cae_o});
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(96153));
      for (int m = 1; m >= 0; m--)
      begin
         md = 1'(m);
         do_reset(md, md ? 1'b0 : 1'($urandom_range(1)));
         for (int k = 0; k < 4; k++)
         begin
            b = (k == 0) ? 8'hA5 : (k == 1) ? 8'hFF : 8'($urandom);
            c = 1'($urandom_range(1));
            u_lhnsp_host.xfer(md, 1'b1, c, b, r);
            wait_busy(1'b0);
            q.push_back({c, b});
            if (k[0])
            begin
               // Full buffer must keep busy low despite done
               proc_done = 1'b1;
               u_lhnsp_host.tick(6);
               check("busy full", 9'h0, {8'h0, busy_n});
               pop();
               pop();
            end
            release_busy();
         end
         tx_data = 8'($urandom);
         tx_load = 1'b1;
         u_lhnsp_host.tick(1);
         tx_load = 1'b0;
         u_lhnsp_host.tick(1);
         check("read oe", md ? 9'hF : 9'h8, {5'h0, d_oe});
         u_lhnsp_host.sel(1'b1);
         // Edges while deselected must be ignored; reloads of the same byte are taken
         tx_load = 1'($urandom_range(1));
         u_lhnsp_host.jitter(8);
         tx_load = 1'b0;
         u_lhnsp_host.tick(4);
         check("deselect", 9'h0, {4'h0, d_oe, busy_oe});
         u_lhnsp_host.sel(1'b0);
         u_lhnsp_host.tick(8);
         u_lhnsp_host.xfer(md, 1'b0, 1'b0, 8'h00, r);
         check("read", {1'b0, tx_data}, {1'b0, r});
         wait_busy(1'b0);
         release_busy();
      end
      complete_run();
   end
endmodule
